//--- hw/acpoc_top.sv
// module: clock divider, power modes, output format and gating of the converter back end
`timescale 1ns/1ns
module acpoc_top #(
  parameter int DEPTH = acpoc_pkg::LATENCY
) (
  input wire logic clk,                // sample clock input
  input wire logic arst_n,             // async reset, active low
  input wire logic [13:0] adc_sample,  // core conversion result
  input wire logic spi_mode,           // serial control active
  input wire logic power_down_pin,     // pin mode power-down
  input wire logic mode_pin,           // serial mode multi-function pin
  input wire logic serial_clock_format_select_pin, // pin mode format strap
  input wire logic [1:0] clk_div_sel,  // divider ratio code
  input wire logic cfg_we,             // register write strobe
  input wire logic [7:0] cfg_addr,     // register address
  input wire logic [7:0] cfg_wdata,    // register write data
  input wire logic [1:0] pwr_cmd,      // serial power command
  output logic [7:0] cfg_rdata,        // register read data
  output logic [14:0] data_out,        // parallel output bus
  output logic [14:0] data_oe,         // output enables
  output logic data_capture_clock_out, // data clock
  output logic dco_oe,                 // data clock enable
  output logic ref_on,                 // reference powered
  output logic core_run                // conversion active
);
  // ***************
  // reset and pins
  // ***************
  logic rs1_r, rs2_r;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rs1_r <= 1'b0;
      rs2_r <= 1'b0;
    end else begin
      rs1_r <= 1'b1;
      rs2_r <= rs1_r;
    end
  end
  wire rst_n = rs2_r;
  logic [3:0] pa_r, pb_r;
  // no reset: strap level must already stand when reset lifts
  always_ff @(posedge clk) begin
    pa_r <= {spi_mode, power_down_pin, mode_pin, serial_clock_format_select_pin};
    pb_r <= pa_r;
  end
  wire spi_s = pb_r[3];
  wire pdp_s = pb_r[2];
  wire mode_s = pb_r[1];
  wire fmt_s = pb_r[0];
  logic strap_fmt_r, strap_done_r;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      strap_fmt_r <= 1'b0;
      strap_done_r <= 1'b0;
    end else if (!strap_done_r) begin
      strap_fmt_r <= fmt_s;
      strap_done_r <= 1'b1;
    end
  end
  // ***************
  // register output_mode_config
  // ***************
  logic [7:0] out_mode_r;
  wire hit = cfg_addr == acpoc_pkg::OUT_MODE_OFS;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) out_mode_r <= acpoc_pkg::OUT_MODE_RST;
    else if (cfg_we && hit) out_mode_r <= cfg_wdata;
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) cfg_rdata <= 8'h00;
    else cfg_rdata <= hit ? out_mode_r : 8'h00;
  end
  wire oeb_en = spi_s && (out_mode_r[6:5] == acpoc_pkg::OEB_SEL_CODE);
  wire dco_inv = out_mode_r[acpoc_pkg::DCO_INV_BIT];
  // ***************
  // clock divider
  // ***************
  // ratio select
  logic [1:0] div_cnt_r;
  wire [1:0] div_max = (clk_div_sel == acpoc_pkg::DIV_BY4) ? 2'h3 :
                       (clk_div_sel == acpoc_pkg::DIV_BY2) ? 2'h1 : 2'h0;
  wire tick = div_cnt_r >= div_max;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) div_cnt_r <= 2'h0;
    else div_cnt_r <= tick ? 2'h0 : div_cnt_r + 2'h1;
  end
  // ***************
  // power state
  // ***************
  acpoc_pkg::acpoc_pwr_t pwr_r, pwr_nxt;
  wire down_req = spi_s ? (mode_s && !oeb_en) || (pwr_cmd == 2'h2) : pdp_s;
  wire stby_req = spi_s && (pwr_cmd == 2'h1);
  always_comb begin
    case (pwr_r)
      default: pwr_nxt = down_req ? acpoc_pkg::ACPOC_PWR_DOWN :
                         stby_req ? acpoc_pkg::ACPOC_PWR_STANDBY : acpoc_pkg::ACPOC_PWR_RUN;
    endcase
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) pwr_r <= acpoc_pkg::ACPOC_PWR_RUN;
    else pwr_r <= pwr_nxt;
  end
  wire running = pwr_r == acpoc_pkg::ACPOC_PWR_RUN;
  // ***************
  // pipeline and format
  // ***************
  acpoc_pipe_if pif ();
  assign pif.adv = tick && running;
  assign pif.din = adc_sample;
  acpoc_pipe #(.DEPTH(DEPTH)) u_pipe (.clk(clk), .rst_n(rst_n), .p(pif));
  wire [1:0] fmt = spi_s ? out_mode_r[1:0] : {1'b0, strap_fmt_r};
  wire [13:0] tw = {~pif.dout[13], pif.dout[12:0]};
  wire [13:0] gr = pif.dout ^ {1'b0, pif.dout[13:1]};
  wire [13:0] fmt_d = (fmt == 2'h1) ? tw : (fmt == 2'h2) ? gr : pif.dout;
  logic adv_d_r;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) adv_d_r <= 1'b0;
    else adv_d_r <= pif.adv;
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) data_out <= 15'h0000;
    else if (adv_d_r) data_out <= {1'b0, fmt_d};
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) data_capture_clock_out <= 1'b0;
    // divide by one: toggle per word, no room for a mid-word edge
    else if (div_max == 2'h0 && pif.adv) data_capture_clock_out <= ~data_capture_clock_out;
    else if (adv_d_r) data_capture_clock_out <= dco_inv;
    else if (pif.adv) data_capture_clock_out <= ~dco_inv;
  end
  wire drive = (pwr_nxt != acpoc_pkg::ACPOC_PWR_DOWN) && !(oeb_en && mode_s);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      data_oe <= 15'h0000;
      dco_oe <= 1'b0;
      ref_on <= 1'b0;
      core_run <= 1'b0;
    end else begin
      data_oe <= {15{drive}};
      dco_oe <= drive;
      ref_on <= pwr_nxt != acpoc_pkg::ACPOC_PWR_DOWN;
      core_run <= pwr_nxt == acpoc_pkg::ACPOC_PWR_RUN;
    end
  end
  // ***************
  // checks
  // ***************
  property p_float_down;
    @(posedge clk) disable iff (!rst_n) (pwr_r == acpoc_pkg::ACPOC_PWR_DOWN) |-> !dco_oe;
  endproperty
  a_float_down: assert property (p_float_down) else $error("drivers on in power-down");
  property p_pin_down;
    @(posedge clk) disable iff (!rst_n) (!spi_s && pdp_s) |=> !core_run;
  endproperty
  a_pin_down: assert property (p_pin_down) else $error("pin power-down ignored");
  property p_wake;
    @(posedge clk) disable iff (!rst_n) (!spi_s && !pdp_s) |=> core_run;
  endproperty
  a_wake: assert property (p_wake) else $error("no return to run");
  property p_stby;
    @(posedge clk) disable iff (!rst_n) (pwr_r == acpoc_pkg::ACPOC_PWR_STANDBY) |-> ref_on;
  endproperty
  a_stby: assert property (p_stby) else $error("reference off in standby");
  property p_oeb;
    @(posedge clk) disable iff (!rst_n) (oeb_en && mode_s) |=> !data_oe[0];
  endproperty
  a_oeb: assert property (p_oeb) else $error("outputs driven with disable high");
  property p_sel;
    @(posedge clk) disable iff (!rst_n) (spi_s && mode_s && !oeb_en) |=> !core_run;
  endproperty
  a_sel: assert property (p_sel) else $error("mode pin power-down ignored");
  property p_div4;
    @(posedge clk) disable iff (!rst_n)
      (clk_div_sel == acpoc_pkg::DIV_BY4 && $stable(clk_div_sel) && tick) |=> !tick [*3];
  endproperty
  a_div4: assert property (p_div4) else $error("divide by four spacing wrong");
  property p_dout;
    @(posedge clk) disable iff (!rst_n) !adv_d_r |=> $stable(data_out);
  endproperty
  a_dout: assert property (p_dout) else $error("output changed off edge");
endmodule : acpoc_top

//--- inc/acpoc_pkg.sv
// package: constants and types of the converter clock, power and output control
package acpoc_pkg;
  localparam int DATA_W = 14;
  localparam int BUS_W = 15;
  localparam int LATENCY = 8;
  localparam logic [7:0] OUT_MODE_OFS = 8'h08;
  localparam logic [7:0] OUT_MODE_RST = 8'h00;
  localparam int OEB_SEL_LSB = 5;
  localparam logic [1:0] OEB_SEL_CODE = 2'h1;
  localparam int FMT_LSB = 0;
  localparam int DCO_INV_BIT = 2;
  localparam logic [1:0] DIV_BY1 = 2'h0;
  localparam logic [1:0] DIV_BY2 = 2'h1;
  localparam logic [1:0] DIV_BY4 = 2'h2;
  localparam int CLK_MULT_MAX = 4;
  typedef enum logic [1:0] {ACPOC_FMT_OFFSET, ACPOC_FMT_TWOS, ACPOC_FMT_GRAY} acpoc_fmt_t;
  typedef enum logic [1:0] {ACPOC_PWR_RUN, ACPOC_PWR_STANDBY, ACPOC_PWR_DOWN} acpoc_pwr_t;
endpackage : acpoc_pkg

//--- inc/acpoc_pipe_if.sv
// interface: sample stream between control top and latency pipeline
`timescale 1ns/1ns
interface acpoc_pipe_if;
  logic adv;
  logic [13:0] din;
  logic [13:0] dout;
  modport ctrl (output adv, output din, input dout);
  modport pipe (input adv, input din, output dout);
endinterface : acpoc_pipe_if

//--- hw/acpoc_pipe.sv
// module: fixed-latency sample delay line
`timescale 1ns/1ns
module acpoc_pipe #(
  parameter int DEPTH = 8
) (
  input wire logic clk,          // sample clock
  input wire logic rst_n,        // synchronised reset
  acpoc_pipe_if.pipe p           // stream port
);
  logic [13:0] stage_r [DEPTH];
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < DEPTH; i++) stage_r[i] <= 14'h0000;
    end else if (p.adv) begin
      stage_r[0] <= p.din;
      for (int i = 1; i < DEPTH; i++) stage_r[i] <= stage_r[i-1];
    end
  end
  assign p.dout = stage_r[DEPTH-1];
endmodule : acpoc_pipe

//--- tb/acpoc_capture.sv
// capture logic model latching the parallel output bus
`timescale 1ns/1ns
module acpoc_capture (
  input wire logic dclk,      // data clock from device
  input wire logic oe,        // data clock driven
  input wire logic inv,       // latch on falling edge
  input wire logic [14:0] d,  // parallel bus
  output logic [14:0] cap     // last word latched
);
  initial cap = 15'h0;
  always @(posedge dclk) if (!inv && oe) cap <= d;
  always @(negedge dclk) if (inv && oe) cap <= d;
endmodule : acpoc_capture

//--- tb/acpoc_top_tb.sv
// self-checking bench of the clock, power and output control
`timescale 1ns/1ns
module acpoc_top_tb;
  typedef struct {string n; logic [15:0] e; int t;} acpoc_note_t;
  logic clk, arst_n, spi_mode, power_down_pin, mode_pin, strap, cfg_we, inv, dclk, dco_oe;
  logic ref_on, core_run;
  logic [13:0] adc_sample, sd;
  logic [1:0] clk_div_sel, pwr_cmd;
  logic [7:0] cfg_addr, cfg_wdata, cfg_rdata, r;
  logic [14:0] data_out, data_oe, cap, prev;
  logic [15:0] obs;
  acpoc_note_t q[$];
  acpoc_note_t nt;
  event obs_ev;
  int fail_count = 0, comparisons = 0, n;
  acpoc_top i_dut (.clk(clk), .arst_n(arst_n), .adc_sample(adc_sample), .spi_mode(spi_mode),
    .power_down_pin(power_down_pin), .mode_pin(mode_pin),
    .serial_clock_format_select_pin(strap), .clk_div_sel(clk_div_sel), .cfg_we(cfg_we),
    .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .pwr_cmd(pwr_cmd), .cfg_rdata(cfg_rdata),
    .data_out(data_out), .data_oe(data_oe), .data_capture_clock_out(dclk), .dco_oe(dco_oe),
    .ref_on(ref_on), .core_run(core_run));
  acpoc_capture i_cap (.dclk(dclk), .oe(dco_oe), .inv(inv), .d(data_out), .cap(cap));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // ****************
  // result monitor
  // ****************
  initial forever begin
    @(obs_ev);
    nt = q.pop_front();
    comparisons++;
    if (((nt.t == 0) ? (obs === nt.e) : ((obs + nt.t >= nt.e) && (obs <= nt.e + nt.t))) !== 1'b1) begin
      fail_count++;
      $display("Error %s expected %h seen %h", nt.n, nt.e, obs);
    end
  end
  function automatic logic [14:0] fmt(logic [13:0] s, logic [1:0] c);
    case (c)
      2'h1: fmt = {1'b0, ~s[13], s[12:0]};
      2'h2: fmt = {1'b0, s ^ (s >> 1)};
      default: fmt = {1'b0, s};
    endcase
  endfunction : fmt
  task automatic chk(string nm, logic [15:0] e, logic [15:0] g, int t = 0);
    q.push_back('{nm, e, t});
    obs = g;
    -> obs_ev;
    #1;
  endtask : chk
  task automatic step(int k);
    repeat (k) @(posedge clk);
    #5;
  endtask : step
  task automatic wr(logic [7:0] a, logic [7:0] d);
    cfg_addr = a;
    cfg_wdata = d;
    cfg_we = 1'b1;
    step(1);
    cfg_we = 1'b0;
  endtask : wr
  task automatic rd(logic [7:0] a, logic [7:0] e);
    cfg_addr = a;
    step(2);
    chk("cfg_rdata", {8'h00, e}, {8'h00, cfg_rdata});
  endtask : rd
  task automatic pwr(logic [3:0] e);
    step(8);
    chk("power", {12'h000, e}, {12'h000, data_oe[0], dco_oe, ref_on, core_run});
  endtask : pwr
  task automatic finish_test;
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : finish_test
  initial begin
    #(5000 * 100);
    fail_count++;
    finish_test();
  end
  initial begin
    sd = 14'($urandom(94619));
    {arst_n, spi_mode, power_down_pin, mode_pin, cfg_we, inv} = 6'h00;
    {strap, clk_div_sel, pwr_cmd, cfg_addr, cfg_wdata, adc_sample} = {1'b1, 20'h00000, sd};
    step(10);
    arst_n = 1'b1;
    step(40);
    chk("data_out", {1'b0, fmt(sd, 2'h1)}, {1'b0, data_out});
    power_down_pin = 1'b1;
    pwr(4'h0);
    power_down_pin = 1'b0;
    pwr(4'hf);
    $display("pin power test done");
    spi_mode = 1'b1;
    rd(acpoc_pkg::OUT_MODE_OFS, acpoc_pkg::OUT_MODE_RST);
    wr(8'h09, 8'h5a);
    rd(8'h08, acpoc_pkg::OUT_MODE_RST);
    rd(8'h09, 8'h00);
    r = 8'($urandom);
    wr(8'h08, r);
    rd(8'h08, r);
    for (int f = 0; f < 3; f++) begin
      wr(8'h08, {5'h00, f[0], f[1:0]});
      inv = f[0];
      step(40);
      chk("capture", {1'b0, fmt(sd, f[1:0])}, {1'b0, cap});
    end
    $display("register and format test done");
    pwr_cmd = 2'h2;
    pwr(4'h0);
    pwr_cmd = 2'h1;
    step(8);
    chk("standby", 16'h0002, {14'h0000, ref_on, core_run});
    pwr_cmd = 2'h0;
    mode_pin = 1'b1;
    pwr(4'h0);
    mode_pin = 1'b0;
    pwr(4'hf);
    wr(8'h08, 8'h20);
    mode_pin = 1'b1;
    pwr(4'h3);
    mode_pin = 1'b0;
    pwr(4'hf);
    $display("serial power test done");
    for (int d = 0; d < 3; d++) begin
      clk_div_sel = d[1:0];
      step(40);
      n = 0;
      repeat (64) begin
        prev = data_out;
        adc_sample = adc_sample + 14'h0001;
        step(1);
        if (data_out !== prev) n++;
      end
      chk("changes", 16'((64 >> d) - acpoc_pkg::LATENCY + 1), 16'(n), 1);
    end
    // leave divide by four right before its next tick
    prev = data_out;
    while (data_out === prev) step(1);
    step(2);
    clk_div_sel = 2'h0;
    adc_sample = sd;
    step(20);
    adc_sample = ~sd;
    n = 0;
    while (data_out[13:0] !== ~sd && n < 40) begin
      step(1);
      n++;
    end
    chk("latency", 16'(acpoc_pkg::LATENCY + 1), 16'(n), 1);
    $display("divider and latency test done");
    finish_test();
  end
endmodule : acpoc_top_tb
